// [rtl/csl_slice.sv]
// ten-cell logic array block slice with carry-select chain
`timescale 1ns/1ps
`default_nettype none

// How it works
// - each cell has a sixteen-entry lookup table over four inputs
// - each cell has one storage register; output always passes the output register, one or two stages
// - block-wide add_sub selects addition or subtraction at run time
// - add_sub enters as carry only at the first cell of a chain
// - arithmetic cells compute carry for carry-in one and zero; the sum uses the selected carry-in
// - within a segment, both precomputed carries pass to the next higher cell and its sum
// - a chain may start at any cell, marked by a per-cell start bit
// - block carry-in selects precomputed carries; regenerated at cells five and ten
// - block controls come from eight row clock lines or local routing
module csl_slice
    import csl_pkg::*;
#(
    parameter int CELLS    = CSL_CELLS,
    parameter int SEG_CELLS = CSL_SEG_CELLS
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // configuration
    input  wire logic [CELLS*CSL_LUT_BITS-1:0] lut_mask,
    input  wire logic [CELLS-1:0]              arith_mode,
    input  wire logic [CELLS-1:0]              chain_start,
    input  wire logic [CELLS-1:0]              use_register,
    input  wire logic [CSL_SEL_W-1:0]          add_sub_source,
    // block-wide control sources
    input  wire logic [CSL_ROW_CLOCKS-1:0]     row_clock,
    input  wire logic                          local_add_sub,
    // cell data
    input  wire logic [CELLS*CSL_LUT_INPUTS-1:0] cell_in,
    input  wire logic                          block_carry_in,
    // results
    output logic [CELLS-1:0]                   cell_out,
    output logic                               block_carry_out
);
    // refuse shapes the two-segment carry select cannot serve
    if (SEG_CELLS < 1) begin : g_bad_seg
        $error("csl_slice: SEG_CELLS must be at least one");
    end
    if (CELLS != 2 * SEG_CELLS) begin : g_bad_cells
        $error("csl_slice: CELLS must be two segments of SEG_CELLS");
    end
    if (CSL_SEL_W < 4 || CSL_ROW_CLOCKS != 8) begin : g_bad_sel
        $error("csl_slice: control select needs four bits and eight row lines");
    end
    if (CSL_LUT_BITS != (1 << CSL_LUT_INPUTS)) begin : g_bad_lut
        $error("csl_slice: lookup mask must cover every input pattern");
    end

    // one cell lookup: the four inputs address the sixteen-entry mask
    function automatic logic lut_eval(input logic [CSL_LUT_BITS-1:0] mask,
                                      input logic [CSL_LUT_INPUTS-1:0] sel);
        lut_eval = mask[sel];
    endfunction

    // carry out of one full-adder bit
    function automatic logic carry_of(input logic a,
                                      input logic bx,
                                      input logic cin);
        carry_of = (a & bx) | (cin & (a ^ bx));
    endfunction

    logic add_sub;
    logic [CELLS-1:0] c_low;   // carry_if_low chain
    logic [CELLS-1:0] c_high;  // carry_if_high chain
    logic [CELLS-1:0] cell_val;
    logic [1:0] seg_carry;
    logic [CELLS-1:0] next_cell_out;
    logic next_block_carry_out;

    // block control select: code eight is local routing, others a row line
    function automatic logic pick_control(input logic [CSL_SEL_W-1:0]      code,
                                          input logic [CSL_ROW_CLOCKS-1:0] rows,
                                          input logic                      local_line);
        if (code == CSL_SEL_LOCAL)
            pick_control = local_line;
        else
            pick_control = rows[code[2:0]];
    endfunction

    always_comb begin
        add_sub = pick_control(add_sub_source, row_clock, local_add_sub);
    end

    // per-cell lookup, dual carry precompute and carry select
    genvar g;
    generate
        for (g = 0; g < CELLS; g++) begin : g_cell
            logic [CSL_LUT_INPUTS-1:0] ins;
            logic [CSL_LUT_BITS-1:0]   mask;
            logic                      a;
            logic                      b;
            logic                      bx;
            logic                      prev_low;
            logic                      prev_high;
            logic                      seg_in;
            logic                      cin_low;
            logic                      cin_high;
            logic                      cin_sel;
            logic                      carry_low;
            logic                      carry_high;
            logic                      sum_bit;
            logic                      cell_bit;

            assign ins  = cell_in[g*CSL_LUT_INPUTS +: CSL_LUT_INPUTS];
            assign mask = lut_mask[g*CSL_LUT_BITS +: CSL_LUT_BITS];
            assign a    = ins[0];
            assign b    = ins[1];
            assign bx   = b ^ add_sub;

            // carries arriving from the cell below; a segment head has none
            if (g % SEG_CELLS == 0) begin : g_head
                assign prev_low  = 1'b0;
                assign prev_high = 1'b1;
            end else begin : g_body
                assign prev_low  = c_low[g-1];
                assign prev_high = c_high[g-1];
            end

            // first segment follows the block carry, the second the regenerated one
            if (g < SEG_CELLS) begin : g_seg_lo
                assign seg_in = block_carry_in;
            end else begin : g_seg_hi
                assign seg_in = seg_carry[0];
            end

            always_comb begin
                // a fresh chain is seeded by add_sub on both precomputed paths
                if (chain_start[g]) begin
                    cin_low  = add_sub;
                    cin_high = add_sub;
                end else begin
                    cin_low  = prev_low;
                    cin_high = prev_high;
                end
                carry_low  = carry_of(a, bx, cin_low);
                carry_high = carry_of(a, bx, cin_high);
                cin_sel    = seg_in ? cin_high : cin_low;
                sum_bit    = a ^ bx ^ cin_sel;
                if (arith_mode[g]) begin
                    cell_bit = sum_bit;
                end else begin
                    cell_bit = lut_eval(mask, ins);
                end
            end

            // carries handed to the next higher cell
            assign c_low[g]    = carry_low;
            assign c_high[g]   = carry_high;
            assign cell_val[g] = cell_bit;
        end
    endgenerate

    // carry regenerated at each segment end (fifth and tenth cell)
    generate
        for (genvar s = 0; s < 2; s++) begin : g_seg
            logic seg_sel;
            if (s == 0) begin : g_first
                assign seg_sel = block_carry_in;
            end else begin : g_next
                assign seg_sel = seg_carry[s-1];
            end
            assign seg_carry[s] = seg_sel ? c_high[(s+1)*SEG_CELLS-1] : c_low[(s+1)*SEG_CELLS-1];
        end
    endgenerate

    // storage register group, one register per cell
    logic [CELLS-1:0] cell_reg;
    generate
        for (genvar r = 0; r < CELLS; r++) begin : g_store
            logic stored;
            logic next_stored;

            always_comb begin
                next_stored = cell_val[r];
            end

            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    stored <= CSL_REG_RESET;
                end else begin
                    stored <= next_stored;
                end
            end

            assign cell_reg[r] = stored;
        end
    endgenerate

    // block carry-out group: regenerated carry of the tenth cell
    always_comb begin
        next_block_carry_out = seg_carry[1];
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            block_carry_out <= 1'b0;
        end else begin
            block_carry_out <= next_block_carry_out;
        end
    end

    // output group: registered cells show a second stage, others one
    always_comb begin
        for (int i = 0; i < CELLS; i++) begin
            next_cell_out[i] = use_register[i] ? cell_reg[i] : cell_val[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cell_out <= '0;
        end else begin
            cell_out <= next_cell_out;
        end
    end
endmodule : csl_slice

`default_nettype wire

// [include/csl_pkg.sv]
// shared constants for the carry-select logic cell slice
package csl_pkg;
    localparam int CSL_CELLS        = 10;
    localparam int CSL_SEG_CELLS    = 5;
    localparam int CSL_LUT_INPUTS   = 4;
    localparam int CSL_LUT_BITS     = 16;
    localparam int CSL_ROW_CLOCKS   = 8;
    localparam int CSL_SEL_W        = 4;
    localparam logic [3:0] CSL_SEL_LOCAL = 4'h8;
    localparam logic CSL_REG_RESET  = 1'b0;
endpackage : csl_pkg

// [verification/csl_nbr_model.sv]
// neighbouring block handing its registered carry to the slice
`timescale 1ns/1ps
`default_nettype none
module csl_nbr_model (input wire logic clk_sys, input wire logic carry_src, output var logic carry_out = 1'b0);
    always @(posedge clk_sys) carry_out <= carry_src;
endmodule // csl_nbr_model
`default_nettype wire

// [verification/csl_slice_asserts.sv]
// port checker for the carry-select slice
`timescale 1ns/1ps
`default_nettype none
module csl_slice_asserts import csl_pkg::*; #(parameter int CELLS = CSL_CELLS) (
    input wire logic clk_sys, nrst, local_add_sub, block_carry_in, block_carry_out,
    input wire logic [CELLS-1:0] arith_mode, chain_start, use_register, cell_out,
    input wire logic [CELLS*16-1:0] lut_mask,
    input wire logic [CELLS*4-1:0] cell_in,
    input wire logic [3:0] add_sub_source,
    input wire logic [7:0] row_clock);
    wire s = add_sub_source == CSL_SEL_LOCAL ? local_add_sub : row_clock[add_sub_source[2:0]];
    wire lk = arith_mode == 0, ak = &arith_mode, rg = &use_register, dr = use_register == 0;
    wire as = ak && chain_start[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence lut_held_s;
        (lk && rg) [*2];
    endsequence
    sequence sum_held_s;
        (as && rg) [*2];
    endsequence
    rst_a: assert property (disable iff (0) !nrst |=> !cell_out && !block_carry_out) else $error("rst");
    lut_a: assert property (lk && dr |=> cell_out[0] == $past(lut_mask[cell_in[3:0]])) else $error("lut");
    lut9_a: assert property (lk && dr |=> cell_out[9] == $past(lut_mask[144+cell_in[39:36]])) else $error("l9");
    lreg_a: assert property (lut_held_s |=> cell_out[0] == $past(lut_mask[cell_in[3:0]], 2)) else $error("lr");
    sum_a: assert property (as && dr |=> cell_out[0] == $past(^cell_in[1:0])) else $error("sum");
    sreg_a: assert property (sum_held_s |=> cell_out[0] == $past(^cell_in[1:0], 2)) else $error("sr");
    sum5_a: assert property (ak && dr && chain_start[5] |=> cell_out[5] == $past(^cell_in[21:20])) else $error("s5");
    cin_a: assert property (ak && dr && !chain_start[0] |=> cell_out[0] == $past(^cell_in[1:0] ^ s ^ block_carry_in))
        else $error("cin");
endmodule // csl_slice_asserts
bind csl_slice csl_slice_asserts #(.CELLS(CELLS)) i_chk (.*);
`default_nettype wire

// [verification/tb_csl_slice.sv]
// bench for the carry-select slice
`timescale 1ns/1ps
`default_nettype none
module tb_csl_slice;
    logic clk_sys = 0, nrst = 0, local_add_sub = 0, nbr = 0, s, block_carry_in, block_carry_out;
    logic [159:0] lut_mask = {5{32'hE8176996}};
    logic [9:0] arith_mode = 0, chain_start = 1, use_register = 0, cell_out;
    logic [3:0] add_sub_source = 0;
    logic [7:0] row_clock = 8'hA5;
    logic [39:0] cell_in = 0;
    logic [10:0] e;
    int bad_count = 0, n_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    csl_slice i_dut (.*);
    csl_nbr_model i_nbr (.clk_sys, .carry_src(nbr), .carry_out(block_carry_in));
    task cmp(input logic lut_on);
        repeat (1 + use_register[0]) @(posedge clk_sys);
        @(negedge clk_sys);
        n_checks++;
        if ({~lut_on & block_carry_out, cell_out} !== e) begin
            bad_count++;
            $display("mismatch result expected %h seen %h", e, {block_carry_out, cell_out});
        end
    endtask
    task t_lut(input logic r);
        use_register = {10{r}};
        for (int k = 0; k < 16; k++) begin
            cell_in = {10{4'(k)}} ^ 40'h0123456789;
            e = 0;
            for (int i = 0; i < 10; i++) e[i] = lut_mask[16*i+cell_in[4*i+:4]];
            cmp(1);
        end
    endtask
    task t_arith(input logic r);
        arith_mode = '1;
        use_register = {10{r}};
        for (int k = 0; k < 16; k++) begin
            add_sub_source = 4'(k);
            local_add_sub = ~k[0];
            cell_in = {10{4'(k)}};
            s = k == 8 ? local_add_sub : row_clock[k%8];
            e = {1'b0, {10{cell_in[0]}}} + {1'b0, {10{cell_in[1] ^ s}}} + 11'(s);
            cmp(0);
        end
    endtask
    task t_chain;
        add_sub_source = 4'h8;
        cell_in = 40'h1111111111;
        for (int k = 0; k < 4; k++) begin
            chain_start = k[0] ? 10'h020 : 10'h000;
            nbr = k[1];
            e = k == 2 ? 11'h400 : k == 3 ? 11'h3E0 : 11'h3FF;
            @(negedge clk_sys);
            cmp(0);
        end
    endtask
    task finish_test(input int late);
        bad_count += late;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        nrst = 1;
        t_lut(1);
        t_lut(0);
        t_arith(1);
        t_arith(0);
        t_chain;
        finish_test(0);
    end
    initial #5000 finish_test(1);
endmodule // tb_csl_slice
`default_nettype wire
